// ==== logic/imu_delta_angle_accel_output_regs.sv ====
// Output register set: y/z delta angle, x/y/z acceleration high/low words.
// Assumes the serial front end supplies an address and read strobe, and
// the sensor path supplies per-sample results with a valid pulse.
`timescale 1ns/1ps
module imu_delta_angle_accel_output_regs #(
    parameter int INT_DIV = imu_out_pkg::INT_SAMPLE_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_misc_control,
    input wire logic [15:0] i_decimation_setting,
    input wire logic i_ext_sample_clk,
    input wire logic i_sample_valid,
    input wire logic [15:0] i_angle_step_y,
    input wire logic [15:0] i_angle_step_z,
    input wire logic [31:0] i_accel_x,
    input wire logic [31:0] i_accel_y,
    input wire logic [31:0] i_accel_z,
    input wire logic i_rd,
    input wire logic [6:0] i_addr,
    output logic o_sample_tick,
    output logic [15:0] o_angle_weight_mult,
    output logic [15:0] o_rd_data,
    output logic o_rd_hit
);
    logic [1:0] clk_sel;
    logic int_tick;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic ext_tick;
    logic [15:0] angle_y_r;
    logic [15:0] angle_z_r;
    logic [31:0] accel_x_r;
    logic [31:0] accel_y_r;
    logic [31:0] accel_z_r;
    logic [15:0] rd_nxt;
    logic hit_nxt;

    assign clk_sel = i_misc_control[imu_out_pkg::CLK_SEL_MSB:
                                    imu_out_pkg::CLK_SEL_LSB];

    // Internal rate only runs while selected
    sample_tick_gen #(.DIV(INT_DIV)) u_tick (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_run(clk_sel == imu_out_pkg::CLK_SEL_INTERNAL),
        .o_tick(int_tick)
    );

    // External sample clock is asynchronous: two stages, then edge
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= i_ext_sample_clk;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end
    assign ext_tick = ext_s2_r & ~ext_s3_r;

    always_comb begin
        if (clk_sel == imu_out_pkg::CLK_SEL_INTERNAL) begin
            o_sample_tick = int_tick;
        end else begin
            o_sample_tick = ext_tick;
        end
    end

    // Angle count weight = gyro scale * this / f_sample; gyro scale is
    // fixed by the package, rate by the tick source above.
    assign o_angle_weight_mult = i_decimation_setting + 16'h1;

    // One snapshot per processing cycle keeps all words coherent
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            angle_y_r <= imu_out_pkg::REG_RESET;
            angle_z_r <= imu_out_pkg::REG_RESET;
            accel_x_r <= {imu_out_pkg::REG_RESET, imu_out_pkg::REG_RESET};
            accel_y_r <= {imu_out_pkg::REG_RESET, imu_out_pkg::REG_RESET};
            accel_z_r <= {imu_out_pkg::REG_RESET, imu_out_pkg::REG_RESET};
        end else if (i_sample_valid) begin
            angle_y_r <= i_angle_step_y;
            angle_z_r <= i_angle_step_z;
            accel_x_r <= i_accel_x;
            accel_y_r <= i_accel_y;
            accel_z_r <= i_accel_z;
        end
    end

    // Read-only decode; writes have no port, unmapped reads give zero
    always_comb begin
        rd_nxt = 16'h0000;
        hit_nxt = 1'b1;
        case (i_addr)
            imu_out_pkg::OFF_ACCEL_X_LOW: begin
                rd_nxt = accel_x_r[15:0];
            end
            imu_out_pkg::OFF_ACCEL_X_HIGH: begin
                rd_nxt = accel_x_r[31:16];
            end
            imu_out_pkg::OFF_ACCEL_Y_LOW: begin
                rd_nxt = accel_y_r[15:0];
            end
            imu_out_pkg::OFF_ACCEL_Y_HIGH: begin
                rd_nxt = accel_y_r[31:16];
            end
            imu_out_pkg::OFF_ACCEL_Z_LOW: begin
                rd_nxt = accel_z_r[15:0];
            end
            imu_out_pkg::OFF_ACCEL_Z_HIGH: begin
                rd_nxt = accel_z_r[31:16];
            end
            imu_out_pkg::OFF_ANGLE_STEP_Y: rd_nxt = angle_y_r;
            imu_out_pkg::OFF_ANGLE_STEP_Z: rd_nxt = angle_z_r;
            default: hit_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= 16'h0000;
            o_rd_hit <= 1'b0;
        end else if (i_rd) begin
            o_rd_data <= rd_nxt;
            o_rd_hit <= hit_nxt;
        end
    end
endmodule : imu_delta_angle_accel_output_regs

// ==== logic/imu_out_pkg.sv ====
// Offsets, field positions, scale constants for the output register set.
// Assumes a 100 MHz system clock and a 16-bit register read port.
package imu_out_pkg;
    localparam int ADDR_W = 7;
    localparam logic [6:0] OFF_ACCEL_X_LOW = 7'h10;
    localparam logic [6:0] OFF_ACCEL_X_HIGH = 7'h12;
    localparam logic [6:0] OFF_ACCEL_Y_LOW = 7'h14;
    localparam logic [6:0] OFF_ACCEL_Y_HIGH = 7'h16;
    localparam logic [6:0] OFF_ACCEL_Z_LOW = 7'h18;
    localparam logic [6:0] OFF_ACCEL_Z_HIGH = 7'h1a;
    localparam logic [6:0] OFF_ANGLE_STEP_Y = 7'h26;
    localparam logic [6:0] OFF_ANGLE_STEP_Z = 7'h28;
    localparam int CLK_SEL_LSB = 2;
    localparam int CLK_SEL_MSB = 3;
    localparam logic [1:0] CLK_SEL_INTERNAL = 2'h0;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Rates in Hz; weights in micro-units per count
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int INT_SAMPLE_HZ = 2048;
    localparam int INT_SAMPLE_CYCLES = SYS_CLK_HZ / INT_SAMPLE_HZ;
    localparam int GYRO_SCALE_UDPS = 5000;
    localparam int ACCEL_SCALE_UMG = 250;
endpackage : imu_out_pkg

// ==== logic/sample_tick_gen.sv ====
// Internal sample-rate tick divider.
// Assumes one system clock; tick is a one-cycle enable.
`timescale 1ns/1ps
module sample_tick_gen #(
    parameter int DIV = imu_out_pkg::INT_SAMPLE_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_run,
    output logic o_tick
);
    initial begin
        if (DIV < 2) $error("DIV too small");
    end
    logic [31:0] cnt_r;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 32'h0;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt_r <= 32'h0;
            o_tick <= 1'b0;
        end else if (cnt_r == 32'(DIV - 1)) begin
            cnt_r <= 32'h0;
            o_tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            o_tick <= 1'b0;
        end
    end
endmodule : sample_tick_gen

// ==== testbench/ext_clk_src.sv ====
// Host-side model: external sample clock source.
// Assumes the bench gates it; stands low while disabled.
`timescale 1ns/1ps
module ext_clk_src (
    input wire logic i_en,
    output logic o_clk
);
    initial o_clk = 1'b0;
    always #50 o_clk = i_en ? ~o_clk : 1'b0;
endmodule : ext_clk_src

// ==== testbench/imu_out_assertions.sv ====
// Port checker for the output register set.
// Assumes bind by matching port names.
`timescale 1ns/1ps
module imu_out_assertions (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_decimation_setting,
    input wire logic i_sample_valid,
    input wire logic [15:0] i_angle_step_y,
    input wire logic [31:0] i_accel_x,
    input wire logic i_rd,
    input wire logic [6:0] i_addr,
    input wire logic o_sample_tick,
    input wire logic [15:0] o_angle_weight_mult,
    input wire logic [15:0] o_rd_data,
    input wire logic o_rd_hit
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    weight_mult_a: assert property (
        o_angle_weight_mult == i_decimation_setting + 16'h1) else $error("w");
    angle_y_a: assert property (i_sample_valid ##1 (i_rd &&
        !i_sample_valid && i_addr == 7'h26) |=>
        o_rd_data == $past(i_angle_step_y, 2)) else $error("ang y");
    accel_high_a: assert property (i_sample_valid ##1 (i_rd &&
        !i_sample_valid && i_addr == 7'h12) |=>
        o_rd_data == $past(i_accel_x[31:16], 2)) else $error("acc hi");
    accel_low_a: assert property (i_sample_valid ##1 (i_rd &&
        !i_sample_valid && i_addr == 7'h10) |=>
        o_rd_data == $past(i_accel_x[15:0], 2)) else $error("acc lo");
    mapped_hit_a: assert property (
        i_rd && i_addr inside {7'h16, 7'h1a} |=> o_rd_hit) else $error("hit");
    unmapped_rd_a: assert property (i_rd && i_addr == 7'h7f |=>
        !o_rd_hit && o_rd_data == 16'h0000) else $error("unmapped");
    rd_stands_a: assert property (!i_rd |=> $stable(o_rd_data) &&
        $stable(o_rd_hit)) else $error("rd hold");
    tick_single_a: assert property (
        o_sample_tick |=> !o_sample_tick) else $error("tick");
endmodule : imu_out_assertions
bind imu_delta_angle_accel_output_regs imu_out_assertions imu_out_chk_i (.*);

// ==== testbench/tb.sv ====
// Self-checking bench for the output register set.
// Assumes a short internal divider of 10 cycles.
`timescale 1ns/1ps
module tb;
    logic i_sys_clk, i_rst_n, i_ext_sample_clk, i_sample_valid, i_rd, ext_en;
    logic [15:0] i_misc_control, i_decimation_setting, o_angle_weight_mult;
    logic [15:0] i_angle_step_y, i_angle_step_z, o_rd_data;
    logic [31:0] i_accel_x, i_accel_y, i_accel_z;
    logic [6:0] i_addr;
    logic o_sample_tick, o_rd_hit;
    int mismatches, num_checks, n;
    imu_delta_angle_accel_output_regs #(.INT_DIV(10))
        imu_delta_angle_accel_output_regs_i (.*);
    ext_clk_src ext_clk_src_i (.i_en(ext_en), .o_clk(i_ext_sample_clk));
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    // Leaves the strobe high so reads can run back to back
    task automatic rd(logic [6:0] a, logic [15:0] exp, logic hit);
        i_rd = 1'b1;
        i_addr = a;
        @(negedge i_sys_clk);
        check("rd_data", o_rd_data, exp);
        check("rd_hit", {15'h0, o_rd_hit}, {15'h0, hit});
    endtask : rd
    task automatic count(int cyc);
        n = 0;
        repeat (cyc) begin
            @(negedge i_sys_clk);
            n += int'(o_sample_tick === 1'b1);
        end
    endtask : count
    task automatic t_map;
        {i_angle_step_y, i_angle_step_z} = 32'h8000_7fff;
        {i_accel_x, i_accel_y} = 64'h1234_abcd_fedc_0001;
        i_accel_z = 32'h0002_ffff;
        i_sample_valid = 1'b1;
        @(negedge i_sys_clk) i_sample_valid = 1'b0;
        rd(7'h26, 16'h8000, 1'b1);
        rd(7'h28, 16'h7fff, 1'b1);
        rd(7'h12, 16'h1234, 1'b1);
        rd(7'h10, 16'habcd, 1'b1);
        rd(7'h16, 16'hfedc, 1'b1);
        rd(7'h14, 16'h0001, 1'b1);
        rd(7'h1a, 16'h0002, 1'b1);
        rd(7'h18, 16'hffff, 1'b1);
        rd(7'h7f, 16'h0000, 1'b0);
        i_angle_step_y = 16'h0001;
        i_sample_valid = 1'b1;
        rd(7'h26, 16'h8000, 1'b1);
        i_sample_valid = 1'b0;
        rd(7'h26, 16'h0001, 1'b1);
        i_accel_x = 32'h5a5a_c3c3;
        i_sample_valid = 1'b1;
        @(negedge i_sys_clk) i_sample_valid = 1'b0;
        rd(7'h12, 16'h5a5a, 1'b1);
        i_sample_valid = 1'b1;
        @(negedge i_sys_clk) i_sample_valid = 1'b0;
        rd(7'h10, 16'hc3c3, 1'b1);
        i_rd = 1'b0;
        $display("map done");
    endtask : t_map
    task automatic t_rate;
        i_decimation_setting = 16'h0009;
        @(negedge i_sys_clk);
        check("mult", o_angle_weight_mult, 16'h000a);
        count(100);
        check("int ticks", 16'(n), 16'd10);
        for (int s = 1; s < 4; s++) begin
            i_misc_control = 16'(s << 2);
            ext_en = 1'b1;
            count(200);
            check("ext ticks", 16'(n >= 19 && n <= 21), 16'h1);
            ext_en = 1'b0;
            count(60);
            check("ext idle", 16'(n), 16'h0);
        end
        $display("rate done");
    endtask : t_rate
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        #100us;
        mismatches++;
        final_report();
    end
    initial begin
        {i_rst_n, i_sample_valid, i_rd, ext_en, i_addr} = '0;
        {i_misc_control, i_decimation_setting} = '0;
        {i_angle_step_y, i_angle_step_z} = '0;
        {i_accel_x, i_accel_y, i_accel_z} = '0;
        repeat (16) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        rd(7'h26, 16'h0000, 1'b1);
        i_rd = 1'b0;
        t_map();
        t_rate();
        final_report();
    end
endmodule : tb
